// ### wdtsm_asserts.sv
// Port checker for the watchdog top
`timescale 1ns/100ps
`default_nettype none
module wdtsm_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [1:0] wdt_mode_cfg_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic sleep_i,
  input wire logic osc_fail_i,
  input wire logic osc_startup_timer_i,
  input wire logic system_reset_o,
  input wire logic wake_o,
  input wire logic timeout_flag_n_o
);
  // ---
  // Timing relations at the ports
  // ---
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");
  property p_rst_pulse; system_reset_o |=> !system_reset_o && !wake_o; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  property p_wake; wake_o |-> $past(sleep_i) || $past(sleep_i, 2); endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_to_flag; system_reset_o |-> ##[0:1] !timeout_flag_n_o; endproperty
  a_to_flag: assert property (p_to_flag) else $error("time-out flag not set");
  property p_clr; clear_watchdog_instr_i |-> ##2 !system_reset_o && !wake_o; endproperty
  a_clr: assert property (p_clr) else $error("event after clear");
  property p_fail; osc_fail_i |-> ##2 !system_reset_o && !wake_o; endproperty
  a_fail: assert property (p_fail) else $error("event after osc fail");
  property p_ost; osc_startup_timer_i |-> ##2 !system_reset_o && !wake_o; endproperty
  a_ost: assert property (p_ost) else $error("event during start-up");
  property p_off; (wdt_mode_cfg_i == 2'h0)[*4] |-> !system_reset_o && !wake_o; endproperty
  a_off: assert property (p_off) else $error("event while off");
  property p_off_slp; (wdt_mode_cfg_i == 2'h2 && sleep_i)[*4] |-> !wake_o; endproperty
  a_off_slp: assert property (p_off_slp) else $error("wake while off asleep");
endmodule
`default_nettype wire

// ### wdtsm_cnt_if.sv
// Interface between the watchdog top and its counter
`timescale 1ns/100ps
`default_nettype none
interface wdtsm_cnt_if;
  logic tick;          // One-cycle low-frequency tick enable
  logic clear;         // Clear count this cycle
  logic run;           // Counting allowed
  logic [4:0] sel;     // Prescale select code
  logic [22:0] count;  // Current count
  logic timeout;       // One-cycle time-out pulse

  modport ctrl (output tick, output clear, output run, output sel,
                input count, input timeout);
  modport cnt (input tick, input clear, input run, input sel,
               output count, output timeout);
endinterface
`default_nettype wire

// ### wdtsm_counter.sv
// Prescaled watchdog tick counter with time-out detection
`timescale 1ns/100ps
`default_nettype none
module wdtsm_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  wdtsm_cnt_if.cnt bus
);
  logic [22:0] next_count; // Next count value
  logic next_timeout;      // Next time-out pulse

  // Terminal count (division ratio minus one) for a prescale code; reserved codes give 1:32
  function automatic logic [22:0] limit_of(input logic [4:0] sel);
    logic [4:0] code;
    code = (sel > wdtsm_pkg::PS_MAX) ? 5'h00 : sel;
    limit_of = 23'((24'h1 << (wdtsm_pkg::PS_BASE_LOG2 + int'(code))) - 24'h1);
  endfunction

  // ----------------------------------------
  // Count, clear and time-out
  // ----------------------------------------
  always_comb begin
    next_count = bus.count;
    next_timeout = 1'b0;
    if (bus.clear || !bus.run) begin
      next_count = 23'h000000;
    end else if (bus.tick) begin
      if (bus.count == limit_of(bus.sel)) begin
        next_count = 23'h000000;
        next_timeout = 1'b1;
      end else begin
        next_count = bus.count + 23'h000001;
      end
    end
  end

  // Count registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus.count <= 23'h000000;
      bus.timeout <= 1'b0;
    end else begin
      bus.count <= next_count;
      bus.timeout <= next_timeout;
    end
  end
endmodule
`default_nettype wire

// ### wdtsm_osc_model.sv
// Low-frequency oscillator model feeding the tick input
`timescale 1ns/100ps
`default_nettype none
module wdtsm_osc_model #(
  parameter int HALF = 4 // Clock cycles per half period
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic osc_o
);
  int cnt; // Cycles into this half period
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      osc_o <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      osc_o <= ~osc_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### wdtsm_pkg.sv
// Constants and types shared by the watchdog timer files
package wdtsm_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0; // Watchdog control register
  localparam logic [3:0] ADDR_STATUS = 4'h4;  // Flags and live state
  localparam logic [3:0] ADDR_CLEAR = 4'h8;   // Write bit 0 to clear the count
  localparam logic [3:0] ADDR_COUNT = 4'hC;   // Current tick count

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTL_SWEN_BIT = 0;    // Software enable bit position
  localparam int CTL_PS_LSB = 1;      // Prescale select low bit
  localparam int CTL_PS_MSB = 5;      // Prescale select high bit
  localparam logic [7:0] CTL_RESET = 8'h16; // Prescale 01011, enable 0
  localparam logic [7:0] CTL_MASK = 8'h3F;  // Bits 7-6 read as zero

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int ST_TO_BIT = 0;     // Time-out flag, active low
  localparam int ST_PD_BIT = 1;     // Power-down flag, active low
  localparam int ST_ACTIVE_BIT = 2; // Watchdog currently active
  localparam int ST_SLEEP_BIT = 3;  // Device in Sleep

  // ----------------------------------------
  // Prescaler figures
  // ----------------------------------------
  localparam int PS_BASE_LOG2 = 5;      // Code 0 divides by 32
  localparam logic [4:0] PS_MAX = 5'h12; // Highest valid code, 1:2^23
  localparam int CNT_W = 23;             // Counter width for 2^23

  // Operating mode field values
  typedef enum logic [1:0] {
    WDTSM_OFF = 2'h0,
    WDTSM_SW = 2'h1,
    WDTSM_AWAKE = 2'h2,
    WDTSM_ON = 2'h3
  } wdtsm_mode_e;
endpackage

// ### wdtsm_tick_sync.sv
// Synchroniser turning the low-frequency oscillator into a tick enable
`timescale 1ns/100ps
`default_nettype none
module wdtsm_tick_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_i,
  output logic tick_o
);
  logic meta;       // First synchroniser stage
  logic stable;     // Second synchroniser stage
  logic last;       // Previous stable level
  logic next_tick;  // Rising edge found

  // ----------------------------------------
  // Edge detection on the stable level only
  // ----------------------------------------
  always_comb begin
    next_tick = stable & ~last;
  end

  // Two-stage synchroniser and edge register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      meta <= osc_i;
      stable <= meta;
      last <= stable;
      tick_o <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ### wdtsm_top.sv
// Watchdog timer with sleep modes and a classic Wishbone register port
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Time-out while awake forces a system reset
// - Counter ticks from low-frequency oscillator only
// - Mode 11: always active, even asleep
// - Mode 10: active awake, off in Sleep
// - Mode 01: software enable bit decides
// - Mode 00: always disabled
// - Five-bit prescale selects 1 ms to 256 s
// - Reset restores two-second prescale code
// - Reset and clear instruction zero the count
// - Sleep entry clears, then counting may resume
// - Sleep exit clears, held during start-up timer
// - Start-up timer running holds count cleared
// - Interrupt wake clears the count
// - Time-out in Sleep wakes instead of resetting
// - Time-out updates time-out and power-down flags
// - Disabled modes hold count cleared
// - Clock switches leave the count untouched
// - Codes double from 1:32; reserved give 1:32
module wdtsm_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core side
  input wire logic low_freq_internal_osc_i,
  input wire logic [1:0] wdt_mode_cfg_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic sleep_i,
  input wire logic wake_interrupt_i,
  input wire logic osc_fail_i,
  input wire logic osc_startup_timer_i,
  output logic system_reset_o,
  output logic wake_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  wdtsm_cnt_if cnt_if ();       // Link to the counter
  logic [7:0] watchdog_control; // Prescale select and software enable
  logic [7:0] next_control;     // Next control value
  logic sleep_q;                // Sleep level one cycle ago
  logic active;                 // Watchdog active this cycle
  logic clear_req;              // Any clearing condition this cycle
  logic sw_clear;               // Clear written over the bus
  logic bus_hit;                // New bus request this cycle
  logic bus_wr;                 // Write held while ack stands, lands at this edge
  logic [31:0] next_dat;        // Next read data
  logic next_ack;               // Next acknowledge
  logic next_reset;             // Next reset pulse
  logic next_wake;              // Next wake pulse
  logic next_to_n;              // Next time-out flag
  logic next_pd_n;              // Next power-down flag
  wdtsm_pkg::wdtsm_mode_e mode; // Mode from configuration

  // ----------------------------------------
  // Oscillator tick and counter
  // ----------------------------------------
  // independent synchronised tick
  wdtsm_tick_sync u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .osc_i(low_freq_internal_osc_i),
    .tick_o(cnt_if.tick)
  );

  wdtsm_counter u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(cnt_if.cnt)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  always_comb begin
    mode = wdtsm_pkg::wdtsm_mode_e'(wdt_mode_cfg_i);
    case (mode)
      wdtsm_pkg::WDTSM_ON: active = 1'b1;
      wdtsm_pkg::WDTSM_AWAKE: active = ~sleep_i;
      wdtsm_pkg::WDTSM_SW: active = watchdog_control[wdtsm_pkg::CTL_SWEN_BIT];
      default: active = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Clearing conditions
  // ----------------------------------------
  always_comb begin
    clear_req = clear_watchdog_instr_i | sw_clear | osc_fail_i
              | (sleep_i & ~sleep_q) | (~sleep_i & sleep_q)
              | wake_interrupt_i | osc_startup_timer_i;
    // clears act in the same cycle, none missed
    cnt_if.clear = clear_req;
    cnt_if.run = active;
    // nothing here follows system clock changes
    cnt_if.sel = watchdog_control[wdtsm_pkg::CTL_PS_MSB:wdtsm_pkg::CTL_PS_LSB];
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always_comb begin
    bus_hit = cyc_i & stb_i & ~ack_o;
    bus_wr = cyc_i & stb_i & we_i & ack_o;
    next_ack = bus_hit;
    next_dat = 32'h00000000;
    next_control = watchdog_control;
    sw_clear = 1'b0;
    // Writes land at the edge where the master samples ack high
    if (bus_wr && sel_i[0]) begin
      if (adr_i == wdtsm_pkg::ADDR_CONTROL) begin
        next_control = dat_i[7:0] & wdtsm_pkg::CTL_MASK;
      end else if (adr_i == wdtsm_pkg::ADDR_CLEAR) begin
        sw_clear = dat_i[0];
      end
    end
    // Read data is launched with ack and stands for that one cycle
    if (bus_hit && adr_i == wdtsm_pkg::ADDR_CONTROL) begin
      next_dat = {24'h000000, watchdog_control & wdtsm_pkg::CTL_MASK};
    end else if (bus_hit && adr_i == wdtsm_pkg::ADDR_STATUS) begin
      next_dat[wdtsm_pkg::ST_TO_BIT] = timeout_flag_n_o;
      next_dat[wdtsm_pkg::ST_PD_BIT] = powerdown_flag_n_o;
      next_dat[wdtsm_pkg::ST_ACTIVE_BIT] = active;
      next_dat[wdtsm_pkg::ST_SLEEP_BIT] = sleep_i;
    end else if (bus_hit && adr_i == wdtsm_pkg::ADDR_COUNT) begin
      next_dat = {9'h000, cnt_if.count};
    end
  end

  // ----------------------------------------
  // Time-out outcome and status flags
  // ----------------------------------------
  always_comb begin
    next_reset = 1'b0;
    next_wake = 1'b0;
    next_to_n = timeout_flag_n_o;
    next_pd_n = powerdown_flag_n_o;
    // Clear instruction marks a healthy run
    if (clear_watchdog_instr_i || sw_clear) begin
      next_to_n = 1'b1;
      next_pd_n = 1'b1;
    end
    // Sleep entry marks power-down
    if (sleep_i && !sleep_q) begin
      next_pd_n = 1'b0;
    end
    // time-out only from an active count
    if (cnt_if.timeout && active) begin
      // time-out flag wins over a clear
      next_to_n = 1'b0;
      if (sleep_i) begin
        next_wake = 1'b1;
        next_pd_n = 1'b0;
      end else begin
        next_reset = 1'b1;
        next_pd_n = 1'b1;
      end
    end
  end

  // Register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_control <= wdtsm_pkg::CTL_RESET;
      sleep_q <= 1'b0;
      dat_o <= 32'h00000000;
      ack_o <= 1'b0;
      system_reset_o <= 1'b0;
      wake_o <= 1'b0;
      timeout_flag_n_o <= 1'b1;
      powerdown_flag_n_o <= 1'b1;
    end else begin
      watchdog_control <= next_control;
      sleep_q <= sleep_i;
      dat_o <= next_dat;
      ack_o <= next_ack;
      system_reset_o <= next_reset;
      wake_o <= next_wake;
      timeout_flag_n_o <= next_to_n;
      powerdown_flag_n_o <= next_pd_n;
    end
  end
endmodule
`default_nettype wire

// ### wdtsm_top_tb.sv
// Self-checking bench for the watchdog top
`timescale 1ns/100ps
`default_nettype none
module wdtsm_top_tb;
  logic clk, rst, cyc, stb, we, ack, osc, osc_q, clr, slp, wint, fail, osc_startup_timer, srst, wake, to_n, pd_n;
  logic [3:0] adr;
  logic [1:0] mode;
  logic [31:0] dat_w, dat_r, rd;
  logic [11:0] k;
  int errors, comparisons, seed, r;
  // Mode, enable, sleep, prescale code, clear source
  logic [11:0] cases [10] = '{12'hC00, 12'hC0A, 12'hD01, 12'h900, 12'h803,
    12'h400, 12'h704, 12'h200, 12'hC98, 12'h612};
  wdtsm_top i_wdtsm_top (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .low_freq_internal_osc_i(osc), .wdt_mode_cfg_i(mode), .clear_watchdog_instr_i(clr),
    .sleep_i(slp), .wake_interrupt_i(wint), .osc_fail_i(fail), .osc_startup_timer_i(osc_startup_timer),
    .system_reset_o(srst), .wake_o(wake), .timeout_flag_n_o(to_n), .powerdown_flag_n_o(pd_n));
  wdtsm_osc_model i_wdtsm_osc_model (.clk_i(clk), .rst_i(rst), .osc_o(osc));
  // Clock and oscillator edge history
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) osc_q <= osc;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Classic bus cycle held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, dat_w} <= {2'h3, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_r;
    {cyc, stb} <= 2'h0;
    @(posedge clk);
  endtask
  // Clear just after a tick has landed, so no tick straddles it
  task automatic do_clear(input logic [2:0] src);
    @(posedge clk iff (osc && !osc_q));
    // Bus clear starts a cycle earlier so the bench sees the next tick edge
    repeat (src == 3'h3 ? 4 : 5) @(posedge clk);
    if (src == 3'h3) wb(1'b1, 4'h8, 32'h1);
    else if (src == 3'h4) begin
      osc_startup_timer <= 1'b1;
      repeat (80) @(posedge clk);
      osc_startup_timer <= 1'b0;
    end else begin
      {fail, wint, clr} <= 3'h1 << src;
      @(posedge clk);
      {fail, wint, clr} <= 3'h0;
    end
  endtask
  task automatic run_case(input logic [11:0] c);
    int n, ev, lim, exp_n;
    logic act;
    act = c[11:10] == 2'h3 || (c[11:10] == 2'h2 && !c[8]) || (c[11:10] == 2'h1 && c[9]);
    exp_n = (c[7:3] > 5'h12) ? 32 : (32 << c[7:3]);
    lim = act ? exp_n + 1 : 40;
    {mode, slp} <= {c[11:10], c[8]};
    wb(1'b1, 4'h0, {26'h0, c[7:3], c[9]});
    wb(1'b0, 4'h0, 32'h0);
    check(rd, {26'h0, c[7:3], c[9]});
    do_clear(c[2:0]);
    n = 0;
    ev = 0;
    while (n < lim && ev == 0) begin
      @(posedge clk);
      if (osc && !osc_q) n++;
      if (srst === 1'b1) ev = 1;
      if (wake === 1'b1) ev = 2;
    end
    check(n, act ? exp_n : 40);
    check(ev, act ? (c[8] ? 2 : 1) : 0);
    if (ev != 0) begin
      check({pd_n, to_n}, {~c[8], 1'b0});
      wb(1'b0, 4'h4, 32'h0);
      check(rd[1:0], {~c[8], 1'b0});
    end
  endtask
  initial begin
    {seed, errors, comparisons} = {32'd64, 64'd0};
    {cyc, stb, we, clr, slp, wint, fail, osc_startup_timer, adr, dat_w, mode, rst} = {46'h0, 1'b1};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h16);
    wb(1'b0, 4'h4, 32'h0);
    check(rd, 32'h3);
    wb(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    foreach (cases[i]) run_case(cases[i]);
    repeat (6) begin
      r = $random(seed);
      k = {r[3:0], r[8] ? 5'h13 + 5'(r[7:4] % 13) : {4'h0, r[4]}, 3'(r[12:10] % 5)};
      run_case(k);
    end
    // Mid-run reset: defaults come back and the count restarts at zero
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check({srst, wake, pd_n, to_n}, 32'h3);
    wb(1'b0, 4'hC, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 4'h0, 32'h0);
    check(rd, {24'h0, wdtsm_pkg::CTL_RESET});
    test_done();
  end
  // Hang guard
  initial begin
    #(10 * 60000);
    errors++;
    test_done();
  end
endmodule
bind wdtsm_top wdtsm_asserts i_wdtsm_asserts (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .wdt_mode_cfg_i(wdt_mode_cfg_i), .sleep_i(sleep_i),
  .clear_watchdog_instr_i(clear_watchdog_instr_i), .osc_fail_i(osc_fail_i),
  .osc_startup_timer_i(osc_startup_timer_i), .system_reset_o(system_reset_o),
  .wake_o(wake_o), .timeout_flag_n_o(timeout_flag_n_o));
`default_nettype wire
